// ==== core/cspt_core.v ====
// What this block does
// - First trim word at 2008h, oscillator bits 12-6
// - Two-bit power-on trim at bits 4-3
// - Brown-out trim bits 2-0, 000 reserved
// - Other variants: power-on trim bits 5-3
// - Brown-out trim uses same three-bit ordering
// - Three-bit variants read trim top bit one
// - First trim erased only when counter 2008h
// - Second trim erased only when counter 2009h
// - Second word: wake-up, low-voltage trims, top ones
// - Read-only part identification word at 2006h
// - Program-protected memory reads as zeros
// - User IDs, configuration always read true
// - Protected program memory refuses programming
// - Firmware data path ignores data protection
// - IDs and configuration always programmable
// - Removal erase clears all but trim words
// - Data protect zero: program erase clears data
// - Program protect bit active low
// - Data protect bit blocks external data reads
`timescale 1ns/10ps
`include "cspt_consts.vh"
module cspt_core #(
  parameter [1:0] VARIANT = 2'd2,
  parameter PROG_DEPTH = 2048,
  parameter PROG_AW = 11,
  parameter DATA_DEPTH = 256,
  parameter DATA_AW = 8,
  // Arbitrary neutral identification values
  parameter [8:0] PART_CODE = 9'h0a5,
  parameter [4:0] REVISION = 5'h01,
  parameter [13:0] TRIM_FIRST_INIT = 14'h2024,
  parameter [13:0] TRIM_SECOND_INIT = 14'h3fe4
) (
  // Clock and reset
  input wire clock_in,
  input wire nrst_in,
  // Request from programming front end
  input wire req_valid_in,
  input wire [2:0] req_op_in,
  input wire [13:0] req_addr_in,
  input wire [13:0] req_wdata_in,
  // Answer
  output reg resp_valid_out,
  output reg [13:0] resp_data_out,
  output reg refused_out,
  output reg busy_out,
  // Protection state
  output reg program_protect_n_out,
  output reg data_protect_n_out,
  // Trim fields to analog
  output reg [6:0] oscillator_trim_out,
  output reg [2:0] por_trim_out,
  output reg [2:0] brownout_trim_out,
  output reg [2:0] wakeup_threshold_trim_out,
  output reg [2:0] low_voltage_detect_trim_out
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_READ = 2'd1;
  localparam [1:0] ST_ERASE = 2'd2;
  localparam [1:0] RK_PROG = 2'd0;
  localparam [1:0] RK_CFG = 2'd1;
  localparam [1:0] RK_DATA_EXT = 2'd2;
  localparam [1:0] RK_DATA_FW = 2'd3;
  localparam integer PROG_LAST_I = PROG_DEPTH - 1;
  localparam integer DATA_LAST_I = DATA_DEPTH - 1;
  localparam [PROG_AW-1:0] PROG_LAST = PROG_LAST_I[PROG_AW-1:0];
  localparam [DATA_AW-1:0] DATA_LAST = DATA_LAST_I[DATA_AW-1:0];
  localparam CNT_W = (PROG_AW > DATA_AW) ? PROG_AW : DATA_AW;
  // Applies the fixed values of unimplemented trim bits
  function [13:0] cspt_trim_fix;
    input [13:0] word;
    input second;
    input [1:0] variant;
    reg [13:0] w;
    begin
      w = word;
      if (second) begin
        w = w | `CSPT_TRIM2_FIXED_MASK;
      end else if (variant == `CSPT_VAR_POR2) begin
        w[`CSPT_TRIM_TOP_BIT] = 1'b0;
        w[`CSPT_TRIM_GAP_BIT] = 1'b0;
      end else begin
        w[`CSPT_TRIM_TOP_BIT] = 1'b1;
      end
      cspt_trim_fix = w;
    end
  endfunction
  function is_uid;
    input [13:0] a;
    begin
      is_uid = (a >= `CSPT_ADDR_UID0) && (a <= `CSPT_ADDR_UID3);
    end
  endfunction
  reg [1:0] state_q;
  reg [1:0] rd_kind_q;
  reg [13:0] cfg_rd_q;
  reg [13:0] config_q;
  reg [13:0] trim_first_q;
  reg [13:0] trim_second_q;
  reg [13:0] uid_q [0:3];
  reg [CNT_W-1:0] erase_cnt_q;
  reg erase_prog_q;
  reg erase_data_q;
  wire is_cfg = req_addr_in[`CSPT_CFG_SPACE_BIT];
  wire prot_prog_on = ~config_q[`CSPT_CFG_PROG_PROT_BIT];
  wire prot_data_on = ~config_q[`CSPT_CFG_DATA_PROT_BIT];
  wire has_second = (VARIANT == `CSPT_VAR_TWO_WORDS);
  wire take = req_valid_in && (state_q == ST_IDLE);
  // Memory ports
  reg prog_we;
  reg [PROG_AW-1:0] prog_waddr;
  reg [13:0] prog_wdata;
  reg data_we;
  reg [DATA_AW-1:0] data_waddr;
  reg [7:0] data_wdata;
  wire [13:0] prog_rdata;
  wire [7:0] data_rdata;
  cspt_mem #(.WIDTH(14), .DEPTH(PROG_DEPTH), .AW(PROG_AW)) u_prog (
    .clock_in(clock_in),
    .wr_en_in(prog_we),
    .wr_addr_in(prog_waddr),
    .wr_data_in(prog_wdata),
    .rd_addr_in(req_addr_in[PROG_AW-1:0]),
    .rd_data_out(prog_rdata)
  );
  cspt_mem #(.WIDTH(8), .DEPTH(DATA_DEPTH), .AW(DATA_AW)) u_data (
    .clock_in(clock_in),
    .wr_en_in(data_we),
    .wr_addr_in(data_waddr),
    .wr_data_in(data_wdata),
    .rd_addr_in(req_addr_in[DATA_AW-1:0]),
    .rd_data_out(data_rdata)
  );

  // Memory write steering
  always @* begin
    prog_we = 1'b0;
    prog_waddr = req_addr_in[PROG_AW-1:0];
    prog_wdata = req_wdata_in;
    data_we = 1'b0;
    data_waddr = req_addr_in[DATA_AW-1:0];
    data_wdata = req_wdata_in[7:0];
    if (state_q == ST_ERASE) begin
      prog_waddr = erase_cnt_q[PROG_AW-1:0];
      prog_wdata = `CSPT_ERASED_WORD;
      prog_we = erase_prog_q && (erase_cnt_q <= PROG_LAST);
      data_waddr = erase_cnt_q[DATA_AW-1:0];
      data_wdata = `CSPT_ERASED_BYTE;
      data_we = erase_data_q && (erase_cnt_q <= DATA_LAST);
    end else if (take) begin
      if (req_op_in == `CSPT_OP_WRITE && !is_cfg && !prot_prog_on) begin
        prog_we = 1'b1;
      end
      // Data writes are allowed under data protection
      if (req_op_in == `CSPT_OP_WRITE_DATA || req_op_in == `CSPT_OP_FW_WRITE_DATA) begin
        data_we = 1'b1;
      end
    end
  end
  // Configuration-space readback
  reg [13:0] cfg_view;
  always @* begin
    cfg_view = `CSPT_ERASED_WORD;
    if (is_uid(req_addr_in)) begin
      cfg_view = uid_q[req_addr_in[1:0]];
    end else if (req_addr_in == `CSPT_ADDR_PART_ID) begin
      cfg_view = {PART_CODE, REVISION};
    end else if (req_addr_in == `CSPT_ADDR_CONFIG) begin
      cfg_view = config_q;
    end else if (req_addr_in == `CSPT_ADDR_TRIM_FIRST) begin
      cfg_view = trim_first_q;
    end else if (req_addr_in == `CSPT_ADDR_TRIM_SECOND && has_second) begin
      cfg_view = trim_second_q;
    end
  end
  // Request handling and erase sweep
  always @(posedge clock_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
      rd_kind_q <= RK_PROG;
      cfg_rd_q <= `CSPT_ZERO_WORD;
      config_q <= `CSPT_RST_CONFIG;
      trim_first_q <= cspt_trim_fix(TRIM_FIRST_INIT, 1'b0, VARIANT);
      trim_second_q <= cspt_trim_fix(TRIM_SECOND_INIT, 1'b1, VARIANT);
      uid_q[0] <= `CSPT_RST_UID;
      uid_q[1] <= `CSPT_RST_UID;
      uid_q[2] <= `CSPT_RST_UID;
      uid_q[3] <= `CSPT_RST_UID;
      erase_cnt_q <= {CNT_W{1'b0}};
      erase_prog_q <= 1'b0;
      erase_data_q <= 1'b0;
      resp_valid_out <= 1'b0;
      resp_data_out <= `CSPT_ZERO_WORD;
      refused_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      resp_valid_out <= 1'b0;
      refused_out <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (req_valid_in) begin
            cfg_rd_q <= cfg_view;
            case (req_op_in)
              `CSPT_OP_READ: begin
                rd_kind_q <= is_cfg ? RK_CFG : RK_PROG;
                state_q <= ST_READ;
                busy_out <= 1'b1;
              end
              `CSPT_OP_READ_DATA: begin
                rd_kind_q <= RK_DATA_EXT;
                state_q <= ST_READ;
                busy_out <= 1'b1;
              end
              `CSPT_OP_FW_READ_DATA: begin
                rd_kind_q <= RK_DATA_FW;
                state_q <= ST_READ;
                busy_out <= 1'b1;
              end
              `CSPT_OP_WRITE: begin
                resp_valid_out <= 1'b1;
                resp_data_out <= req_wdata_in;
                if (!is_cfg) begin
                  refused_out <= prot_prog_on;
                end else if (is_uid(req_addr_in)) begin
                  uid_q[req_addr_in[1:0]] <= req_wdata_in;
                end else if (req_addr_in == `CSPT_ADDR_CONFIG) begin
                  config_q <= req_wdata_in;
                end else if (req_addr_in == `CSPT_ADDR_TRIM_FIRST) begin
                  trim_first_q <= cspt_trim_fix(req_wdata_in, 1'b0, VARIANT);
                end else if (req_addr_in == `CSPT_ADDR_TRIM_SECOND && has_second) begin
                  trim_second_q <= cspt_trim_fix(req_wdata_in, 1'b1, VARIANT);
                end else begin
                  refused_out <= 1'b1;
                end
              end
              `CSPT_OP_WRITE_DATA, `CSPT_OP_FW_WRITE_DATA: begin
                resp_valid_out <= 1'b1;
                resp_data_out <= req_wdata_in;
              end
              `CSPT_OP_ERASE_PROG: begin
                erase_prog_q <= 1'b1;
                // Protected data goes with program memory
                erase_data_q <= prot_data_on || is_cfg;
                erase_cnt_q <= {CNT_W{1'b0}};
                state_q <= ST_ERASE;
                busy_out <= 1'b1;
                if (is_cfg) begin
                  config_q <= `CSPT_ERASED_WORD;
                  uid_q[0] <= `CSPT_ERASED_WORD;
                  uid_q[1] <= `CSPT_ERASED_WORD;
                  uid_q[2] <= `CSPT_ERASED_WORD;
                  uid_q[3] <= `CSPT_ERASED_WORD;
                end
                // Trim survives unless the counter sits on it
                if (req_addr_in == `CSPT_ADDR_TRIM_FIRST) begin
                  trim_first_q <= cspt_trim_fix(`CSPT_ERASED_WORD, 1'b0, VARIANT);
                end
                if (req_addr_in == `CSPT_ADDR_TRIM_SECOND && has_second) begin
                  trim_second_q <= cspt_trim_fix(`CSPT_ERASED_WORD, 1'b1, VARIANT);
                end
              end
              `CSPT_OP_ERASE_DATA: begin
                erase_prog_q <= 1'b0;
                erase_data_q <= 1'b1;
                erase_cnt_q <= {CNT_W{1'b0}};
                state_q <= ST_ERASE;
                busy_out <= 1'b1;
              end
              default: begin
                refused_out <= 1'b1;
              end
            endcase
          end
        end
        ST_READ: begin
          resp_valid_out <= 1'b1;
          busy_out <= 1'b0;
          state_q <= ST_IDLE;
          refused_out <= req_valid_in;
          case (rd_kind_q)
            RK_PROG: resp_data_out <= prot_prog_on ? `CSPT_ZERO_WORD : prog_rdata;
            RK_CFG: resp_data_out <= cfg_rd_q;
            RK_DATA_EXT: resp_data_out <= prot_data_on ? `CSPT_ZERO_WORD : {6'h00, data_rdata};
            RK_DATA_FW: resp_data_out <= {6'h00, data_rdata};
            default: resp_data_out <= `CSPT_ZERO_WORD;
          endcase
        end
        ST_ERASE: begin
          refused_out <= req_valid_in;
          erase_cnt_q <= erase_cnt_q + 1'b1;
          if ((!erase_prog_q || erase_cnt_q >= PROG_LAST)
              && (!erase_data_q || erase_cnt_q >= DATA_LAST)) begin
            state_q <= ST_IDLE;
            busy_out <= 1'b0;
            resp_valid_out <= 1'b1;
            resp_data_out <= `CSPT_ERASED_WORD;
            erase_prog_q <= 1'b0;
            erase_data_q <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

  // Field outputs, registered from the stored words
  always @(posedge clock_in) begin
    if (!nrst_in) begin
      program_protect_n_out <= 1'b1;
      data_protect_n_out <= 1'b1;
      oscillator_trim_out <= 7'h00;
      por_trim_out <= 3'h0;
      brownout_trim_out <= 3'h0;
      wakeup_threshold_trim_out <= 3'h0;
      low_voltage_detect_trim_out <= 3'h0;
    end else begin
      program_protect_n_out <= config_q[`CSPT_CFG_PROG_PROT_BIT];
      data_protect_n_out <= config_q[`CSPT_CFG_DATA_PROT_BIT];
      oscillator_trim_out <= trim_first_q[`CSPT_OSC_TRIM_MSB:`CSPT_OSC_TRIM_LSB];
      if (VARIANT == `CSPT_VAR_POR2) begin
        por_trim_out <= {1'b0, trim_first_q[`CSPT_POR2_TRIM_MSB:`CSPT_POR_TRIM_LSB]};
      end else begin
        por_trim_out <= trim_first_q[`CSPT_POR_TRIM_MSB:`CSPT_POR_TRIM_LSB];
      end
      // Code 000 is passed through; it is reserved in the two-bit variant
      brownout_trim_out <= trim_first_q[`CSPT_BOR_TRIM_MSB:`CSPT_BOR_TRIM_LSB];
      wakeup_threshold_trim_out <= trim_second_q[`CSPT_WUR_TRIM_MSB:`CSPT_WUR_TRIM_LSB];
      low_voltage_detect_trim_out <= trim_second_q[`CSPT_LVD_TRIM_MSB:`CSPT_LVD_TRIM_LSB];
    end
  end
endmodule

// ==== core/cspt_consts.vh ====
`ifndef CSPT_CONSTS_VH
`define CSPT_CONSTS_VH

// Configuration-space addresses (program counter values)
`define CSPT_CFG_BASE 14'h2000
`define CSPT_ADDR_UID0 14'h2000
`define CSPT_ADDR_UID3 14'h2003
`define CSPT_ADDR_PART_ID 14'h2006
`define CSPT_ADDR_CONFIG 14'h2007
`define CSPT_ADDR_TRIM_FIRST 14'h2008
`define CSPT_ADDR_TRIM_SECOND 14'h2009
`define CSPT_CFG_SPACE_BIT 13

// Configuration word protect bits, both active low
`define CSPT_CFG_PROG_PROT_BIT 6
`define CSPT_CFG_DATA_PROT_BIT 7

// First trim word fields
`define CSPT_OSC_TRIM_MSB 12
`define CSPT_OSC_TRIM_LSB 6
`define CSPT_POR_TRIM_MSB 5
`define CSPT_POR_TRIM_LSB 3
`define CSPT_POR2_TRIM_MSB 4
`define CSPT_BOR_TRIM_MSB 2
`define CSPT_BOR_TRIM_LSB 0
`define CSPT_TRIM_TOP_BIT 13
`define CSPT_TRIM_GAP_BIT 5

// Second trim word fields
`define CSPT_WUR_TRIM_MSB 5
`define CSPT_WUR_TRIM_LSB 3
`define CSPT_LVD_TRIM_MSB 2
`define CSPT_LVD_TRIM_LSB 0
`define CSPT_TRIM2_FIXED_MASK 14'h3fc0

// Erased and reset values
`define CSPT_ERASED_WORD 14'h3fff
`define CSPT_ERASED_BYTE 8'hff
`define CSPT_ZERO_WORD 14'h0000
`define CSPT_RST_CONFIG 14'h3fff
`define CSPT_RST_UID 14'h3fff

// Trim word variants
`define CSPT_VAR_POR2 2'd0
`define CSPT_VAR_POR3 2'd1
`define CSPT_VAR_TWO_WORDS 2'd2

// Request operation codes
`define CSPT_OP_READ 3'h0
`define CSPT_OP_WRITE 3'h1
`define CSPT_OP_ERASE_PROG 3'h2
`define CSPT_OP_ERASE_DATA 3'h3
`define CSPT_OP_READ_DATA 3'h4
`define CSPT_OP_WRITE_DATA 3'h5
`define CSPT_OP_FW_READ_DATA 3'h6
`define CSPT_OP_FW_WRITE_DATA 3'h7

`endif

// ==== core/cspt_mem.v ====
`timescale 1ns/10ps
module cspt_mem #(
  parameter WIDTH = 14,
  parameter DEPTH = 2048,
  parameter AW = 11
) (
  // Clock
  input wire clock_in,
  // Write port
  input wire wr_en_in,
  input wire [AW-1:0] wr_addr_in,
  input wire [WIDTH-1:0] wr_data_in,
  // Read port
  input wire [AW-1:0] rd_addr_in,
  output reg [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clock_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule

// ==== tb/cspt_core_props.sv ====
`timescale 1ns/10ps
`include "cspt_consts.vh"
module cspt_core_props #(
  parameter PROG_DEPTH = 2048,
  parameter [8:0] PART_CODE = 9'h0a5,
  parameter [4:0] REVISION = 5'h01
) (
  // Clock and reset
  input wire clock_in,
  input wire nrst_in,
  // Request
  input wire req_valid_in,
  input wire [2:0] req_op_in,
  input wire [13:0] req_addr_in,
  // Answer and protection state
  input wire resp_valid_out,
  input wire [13:0] resp_data_out,
  input wire refused_out,
  input wire busy_out,
  input wire program_protect_n_out,
  input wire data_protect_n_out
);
  localparam int ERASE_LAT = PROG_DEPTH + 1;
  wire go_w = req_valid_in && !busy_out && !resp_valid_out;
  wire wr_w = go_w && req_op_in == `CSPT_OP_WRITE;
  wire rd_w = go_w && req_op_in == `CSPT_OP_READ;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  property p_id_read;
    rd_w && req_addr_in == 14'h2006
    |=> busy_out ##1 (resp_valid_out && resp_data_out == {PART_CODE, REVISION});
  endproperty
  a_id_read: assert property (p_id_read) else $error("part word read wrong");
  property p_id_ro;
    wr_w && req_addr_in == 14'h2006 |=> resp_valid_out && refused_out;
  endproperty
  a_id_ro: assert property (p_id_ro) else $error("part word write taken");
  property p_prot_read;
    rd_w && !req_addr_in[13] && !program_protect_n_out
    |=> ##1 (resp_valid_out && resp_data_out == 14'h0000);
  endproperty
  a_prot_read: assert property (p_prot_read) else $error("protected read not zero");
  property p_prot_write;
    wr_w && !req_addr_in[13] && !program_protect_n_out |=> resp_valid_out && refused_out;
  endproperty
  a_prot_write: assert property (p_prot_write) else $error("protected write taken");
  property p_open_write;
    wr_w && !req_addr_in[13] && program_protect_n_out |=> resp_valid_out && !refused_out;
  endproperty
  a_open_write: assert property (p_open_write) else $error("open write refused");
  property p_cfg_write;
    wr_w && (req_addr_in == 14'h2007 || req_addr_in[13:2] == 12'h800)
    |=> resp_valid_out && !refused_out;
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("id or config refused");
  property p_data_read;
    go_w && req_op_in == `CSPT_OP_READ_DATA && !data_protect_n_out
    |=> busy_out ##1 (resp_valid_out && resp_data_out == 14'h0000);
  endproperty
  a_data_read: assert property (p_data_read) else $error("protected data shown");
  property p_erase_lat;
    go_w && req_op_in == `CSPT_OP_ERASE_PROG
    |-> ##[ERASE_LAT:ERASE_LAT] (resp_valid_out && resp_data_out == 14'h3fff);
  endproperty
  a_erase_lat: assert property (p_erase_lat) else $error("erase answer late");
  property p_busy_end;
    go_w && req_op_in == `CSPT_OP_FW_READ_DATA |=> busy_out ##1 !busy_out;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("firmware read stuck");
endmodule
bind cspt_core cspt_core_props #(.PROG_DEPTH(PROG_DEPTH), .PART_CODE(PART_CODE),
  .REVISION(REVISION)) u_cspt_core_props (.clock_in(clock_in), .nrst_in(nrst_in),
  .req_valid_in(req_valid_in), .req_op_in(req_op_in), .req_addr_in(req_addr_in),
  .resp_valid_out(resp_valid_out), .resp_data_out(resp_data_out),
  .refused_out(refused_out), .busy_out(busy_out),
  .program_protect_n_out(program_protect_n_out), .data_protect_n_out(data_protect_n_out));

// ==== tb/cspt_prog.sv ====
`timescale 1ns/10ps
module cspt_prog (
  // Clock
  input wire clock_in,
  // Request
  output logic req_valid_out,
  output logic [2:0] req_op_out,
  output logic [13:0] req_addr_out,
  output logic [13:0] req_wdata_out,
  // Answer
  input wire resp_valid_in,
  input wire [13:0] resp_data_in,
  input wire refused_in
);
  initial begin
    req_valid_out = 1'b0;
    req_op_out = 3'h0;
    req_addr_out = 14'h0000;
    req_wdata_out = 14'h0000;
  end
  // Address and data stay put until the answer edge, read data is taken there
  task automatic xfer(input logic [2:0] op, input logic [13:0] addr, wdata,
      output logic [13:0] rdata, output logic refused, output logic ok);
    int n;
    @(posedge clock_in);
    #1;
    req_valid_out = 1'b1;
    req_op_out = op;
    req_addr_out = addr;
    req_wdata_out = wdata;
    @(posedge clock_in);
    #1;
    req_valid_out = 1'b0;
    ok = 1'b0;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge clock_in);
      ok = resp_valid_in;
    end
    rdata = resp_data_in;
    refused = refused_in;
    #1;
    // Released lines show the inverse, not a stale value
    req_addr_out = ~addr;
    req_wdata_out = ~wdata;
  endtask
endmodule

// ==== tb/config_space_protection_trim_tb.sv ====
`timescale 1ns/10ps
`include "cspt_consts.vh"
module config_space_protection_trim_tb;
  localparam [8:0] PART = 9'h0a5; // Arbitrary value
  localparam [4:0] REV = 5'h01; // Arbitrary value
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic req_valid, resp_valid, refused, busy, pp_n, dp_n, ok;
  logic [2:0] req_op, por_t, bor_t, wur_t, lvd_t;
  logic [13:0] req_addr, req_wdata, resp_data, sv;
  logic [6:0] osc_t;
  logic [13:0] pm [16];
  logic [13:0] uid [4];
  logic [7:0] dm [16];
  logic [13:0] cfg = 14'h3fff, t1 = 14'h2024, t2 = 14'h3fe4;
  int n_mismatch = 0, samples_checked = 0, seed = 10961, i;
  always #10 clock_in = ~clock_in;
  cspt_core #(.PROG_DEPTH(16), .PROG_AW(4), .DATA_DEPTH(16), .DATA_AW(4),
    .PART_CODE(PART), .REVISION(REV)) u_cspt_core (.clock_in(clock_in), .nrst_in(nrst_in),
    .req_valid_in(req_valid), .req_op_in(req_op), .req_addr_in(req_addr),
    .req_wdata_in(req_wdata), .resp_valid_out(resp_valid), .resp_data_out(resp_data),
    .refused_out(refused), .busy_out(busy), .program_protect_n_out(pp_n),
    .data_protect_n_out(dp_n), .oscillator_trim_out(osc_t), .por_trim_out(por_t),
    .brownout_trim_out(bor_t), .wakeup_threshold_trim_out(wur_t),
    .low_voltage_detect_trim_out(lvd_t));
  cspt_prog u_cspt_prog (.clock_in(clock_in), .req_valid_out(req_valid),
    .req_op_out(req_op), .req_addr_out(req_addr), .req_wdata_out(req_wdata),
    .resp_valid_in(resp_valid), .resp_data_in(resp_data), .refused_in(refused));
  logic [2:0] por_0, bor_0;
  logic [6:0] osc_0;
  // Two-bit power-on trim variant follows the same request stream
  cspt_core #(.VARIANT(2'd0), .PROG_DEPTH(16), .PROG_AW(4), .DATA_DEPTH(16), .DATA_AW(4),
    .PART_CODE(PART), .REVISION(REV)) u_cspt_core_por2 (.clock_in(clock_in),
    .nrst_in(nrst_in), .req_valid_in(req_valid), .req_op_in(req_op), .req_addr_in(req_addr),
    .req_wdata_in(req_wdata), .resp_valid_out(), .resp_data_out(), .refused_out(),
    .busy_out(), .program_protect_n_out(), .data_protect_n_out(),
    .oscillator_trim_out(osc_0), .por_trim_out(por_0), .brownout_trim_out(bor_0),
    .wakeup_threshold_trim_out(), .low_voltage_detect_trim_out());
  task tally_and_finish;
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [13:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Model step, then the real transfer
  task automatic do_op(input logic [2:0] op, input logic [13:0] a, d);
    logic [13:0] e, m, got;
    logic ef, f, cmp;
    ef = 1'b0;
    cmp = 1'b1;
    e = 14'h3fff;
    m = 14'h3fff;
    case (op)
      `CSPT_OP_READ: if (!a[13]) e = cfg[6] ? pm[a[3:0]] : 14'h0000;
        else if (a[13:2] == 12'h800) e = uid[a[1:0]];
        else if (a == 14'h2006) e = {PART, REV};
        else if (a == 14'h2007) e = cfg;
        else if (a == 14'h2008) e = t1;
        else if (a == 14'h2009) e = t2;
      `CSPT_OP_WRITE: begin
        cmp = 1'b0;
        if (!a[13]) begin
          if (cfg[6]) pm[a[3:0]] = d;
          else ef = 1'b1;
        end
        else if (a[13:2] == 12'h800) uid[a[1:0]] = d;
        else if (a == 14'h2007) cfg = d;
        else if (a == 14'h2008) t1 = d | 14'h2000;
        else if (a == 14'h2009) t2 = d | 14'h3fc0;
        else ef = 1'b1;
      end
      `CSPT_OP_ERASE_PROG: begin
        if (!cfg[7] || a[13]) dm = '{default: 8'hff};
        pm = '{default: 14'h3fff};
        if (a[13]) begin
          cfg = 14'h3fff;
          uid = '{default: 14'h3fff};
        end
        if (a == 14'h2008) t1 = 14'h3fff;
        if (a == 14'h2009) t2 = 14'h3fff;
      end
      `CSPT_OP_ERASE_DATA: dm = '{default: 8'hff};
      `CSPT_OP_READ_DATA, `CSPT_OP_FW_READ_DATA: begin
        m = 14'h00ff;
        e = (op == `CSPT_OP_READ_DATA && !cfg[7]) ? 14'h0000 : {6'h00, dm[a[3:0]]};
      end
      default: begin
        cmp = 1'b0;
        dm[a[3:0]] = d[7:0];
      end
    endcase
    u_cspt_prog.xfer(op, a, d, got, f, ok);
    chk({12'h000, ok, f}, {12'h000, 1'b1, ef});
    if (cmp) chk(got & m, e & m);
  endtask
  task fields;
    chk({osc_t, por_t, bor_t, 1'b0}, {t1[12:0], 1'b0});
    chk({8'h00, wur_t, lvd_t}, {8'h00, t2[5:0]});
    chk({osc_0, por_0, bor_0, 1'b0}, {t1[12:6], 1'b0, t1[4:0], 1'b0});
  endtask
  initial begin
    repeat (4) @(posedge clock_in);
    #1 nrst_in = 1'b1;
    do_op(`CSPT_OP_ERASE_PROG, 14'h2000, 14'h0);
    for (i = 0; i < 16; i++) do_op(`CSPT_OP_READ, 14'(i), 14'h0);
    do_op(`CSPT_OP_READ, 14'h2006, 14'h0);
    do_op(`CSPT_OP_WRITE, 14'h2006, 14'h0);
    do_op(`CSPT_OP_READ, 14'h2008, 14'h0);
    do_op(`CSPT_OP_WRITE, 14'h2008, 14'($random(seed)));
    do_op(`CSPT_OP_WRITE, 14'h2009, 14'($random(seed)));
    do_op(`CSPT_OP_READ, 14'h2008, 14'h0);
    do_op(`CSPT_OP_READ, 14'h2009, 14'h0);
    fields;
    for (i = 0; i < 16; i++) begin
      do_op(`CSPT_OP_WRITE, 14'(i), 14'($random(seed)));
      do_op(`CSPT_OP_WRITE_DATA, 14'(i), 14'($random(seed)));
    end
    for (i = 0; i < 16; i++) begin
      do_op(`CSPT_OP_READ, 14'(i), 14'h0);
      do_op(`CSPT_OP_READ_DATA, 14'(i), 14'h0);
    end
    do_op(`CSPT_OP_WRITE, 14'h2007, 14'h3fbf);
    chk({13'h0, pp_n}, 14'h0);
    for (i = 0; i < 4; i++) do_op(`CSPT_OP_READ, 14'(i), 14'h0);
    do_op(`CSPT_OP_WRITE, 14'h3, 14'($random(seed)));
    do_op(`CSPT_OP_WRITE, 14'h2001, 14'($random(seed)));
    do_op(`CSPT_OP_READ, 14'h2001, 14'h0);
    do_op(`CSPT_OP_READ, 14'h2007, 14'h0);
    do_op(`CSPT_OP_WRITE, 14'h2007, 14'h3f3f);
    chk({13'h0, dp_n}, 14'h0);
    do_op(`CSPT_OP_READ_DATA, 14'h5, 14'h0);
    do_op(`CSPT_OP_FW_WRITE_DATA, 14'h6, 14'($random(seed)));
    do_op(`CSPT_OP_FW_READ_DATA, 14'h6, 14'h0);
    do_op(`CSPT_OP_ERASE_PROG, 14'h0, 14'h0);
    do_op(`CSPT_OP_FW_READ_DATA, 14'h5, 14'h0);
    do_op(`CSPT_OP_FW_WRITE_DATA, 14'h5, 14'($random(seed)));
    do_op(`CSPT_OP_ERASE_DATA, 14'h0, 14'h0);
    do_op(`CSPT_OP_FW_READ_DATA, 14'h5, 14'h0);
    sv = t1;
    do_op(`CSPT_OP_ERASE_PROG, 14'h2008, 14'h0);
    do_op(`CSPT_OP_READ, 14'h2008, 14'h0);
    do_op(`CSPT_OP_READ, 14'h2009, 14'h0);
    do_op(`CSPT_OP_WRITE, 14'h2008, sv);
    do_op(`CSPT_OP_ERASE_PROG, 14'h2009, 14'h0);
    do_op(`CSPT_OP_READ, 14'h2009, 14'h0);
    do_op(`CSPT_OP_READ, 14'h2008, 14'h0);
    do_op(`CSPT_OP_READ, 14'h0, 14'h0);
    fields;
    tally_and_finish;
  end
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule
